// File: design/rgmp_pkg.sv
// constants, codes and carriers shared by the rgmii pin port
package rgmp_pkg;

   // system clock and the documented link clock rates, in kHz
   localparam int SYS_CLK_KHZ = 100000;
   localparam int TXC_GIG_KHZ = 125000;
   localparam int TXC_FAST_KHZ = 25000;
   localparam int TXC_TEN_KHZ = 2500;
   localparam int REF_CLK_KHZ = 25000;

   // half periods in system cycles; a rate the system clock cannot reach rounds to one cycle
   localparam int TXC_GIG_HALF_RAW = SYS_CLK_KHZ / (2 * TXC_GIG_KHZ);
   localparam int TXC_FAST_HALF_RAW = SYS_CLK_KHZ / (2 * TXC_FAST_KHZ);
   localparam int TXC_TEN_HALF_RAW = SYS_CLK_KHZ / (2 * TXC_TEN_KHZ);
   localparam int REF_HALF_RAW = SYS_CLK_KHZ / (2 * REF_CLK_KHZ);
   localparam logic [7:0] TXC_GIG_HALF = 8'((TXC_GIG_HALF_RAW < 1) ? 1 : TXC_GIG_HALF_RAW);
   localparam logic [7:0] TXC_FAST_HALF = 8'((TXC_FAST_HALF_RAW < 1) ? 1 : TXC_FAST_HALF_RAW);
   localparam logic [7:0] TXC_TEN_HALF = 8'((TXC_TEN_HALF_RAW < 1) ? 1 : TXC_TEN_HALF_RAW);
   localparam logic [7:0] REF_HALF = 8'((REF_HALF_RAW < 1) ? 1 : REF_HALF_RAW);

   // transceiver reset is held this long after our own reset or a request
   localparam int RST_HOLD_US = 10;
   localparam logic [15:0] RST_HOLD_CYCLES = 16'((RST_HOLD_US * SYS_CLK_KHZ + 999) / 1000);

   // pin synchroniser depth and transmit buffer depth
   localparam int SYNC_STAGES = 3;
   localparam int BUF_DEPTH = 2;

   // pin sampling slots in the synchroniser vector
   localparam int SY_RXC = 0;
   localparam int SY_RXD = 1;
   localparam int SY_RX_CTL = 5;
   localparam int SY_GIG_REF = 6;
   localparam int SY_DUPLEX = 7;
   localparam int SY_WIDTH = 8;

   typedef enum logic [1:0]
   {
      RGMP_SPD_10 = 2'h0,
      RGMP_SPD_100 = 2'h1,
      RGMP_SPD_1000 = 2'h2
   } rgmp_speed_e;

   typedef enum logic
   {
      RGMP_PH_FIRST = 1'h0,
      RGMP_PH_SECOND = 1'h1
   } rgmp_phase_e;

   typedef struct packed
   {
      logic [7:0] data;
      logic err;
   } rgmp_word_s;

endpackage : rgmp_pkg

// File: design/rgmp_buf.sv
// two-entry valid/ready buffer for transmit words
`timescale 1ns/1ps
`default_nettype none
module rgmp_buf
   import rgmp_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire rgmp_word_s in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output rgmp_word_s out_data_out
);

   rgmp_word_s mem_q [BUF_DEPTH];
   rgmp_word_s mem_d [BUF_DEPTH];
   logic wr_q, wr_d, rd_q, rd_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   // full and empty come straight from the fill count
   assign in_ready_out = (cnt_q != 2'h2);
   assign out_valid_out = (cnt_q != 2'h0);
   assign out_data_out = mem_q[rd_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_ready_in & out_valid_out;

   // pointer and storage update
   always_comb
   begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data_in;
         wr_d = ~wr_q;
      end
      if (pop)
      begin
         rd_d = ~rd_q;
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + 2'h1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         mem_q <= '{default: '0};
         wr_q <= 1'h0;
         rd_q <= 1'h0;
         cnt_q <= 2'h0;
      end
      else
      begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

endmodule : rgmp_buf
`default_nettype wire

// File: design/rgmp_port.sv
// rgmii pin port of the mac toward an external gigabit transceiver
// Summary of operation
// - transmit bytes leave as four-bit nibbles on the transmit data lines, low nibble first
// - one transmit control line carries enable on rise, enable xor error on fall
// - transmit clock is driven out at 50, 25 or 2.5 MHz by speed; gigabit is capped at half the system clock
// - receive control line carries valid on rise, valid xor error on fall; decoded here
// - a continuous 25 MHz reference clock is driven to the transceiver
// - gigabit transmit clock may follow the transceiver's 125 MHz reference input
// - duplex input high means full duplex, low means half duplex
// - an active-low reset output holds the transceiver in reset
`timescale 1ns/1ps
`default_nettype none
module rgmp_port
   import rgmp_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [1:0] SPEED_IN,
   input wire logic USE_GIG_REF_IN,
   input wire logic TRANSCEIVER_RST_REQ_IN,
   input wire logic TX_VALID_IN,
   output logic TX_READY_OUT,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic TX_ERR_IN,
   output logic [3:0] TXD_OUT,
   output logic TX_CTL_OUT,
   output logic TXC_OUT,
   input wire logic RXC_IN,
   input wire logic [3:0] RXD_IN,
   input wire logic RX_CTL_IN,
   output logic RX_VALID_OUT,
   output logic [7:0] RX_DATA_OUT,
   output logic RX_ERR_OUT,
   output logic RX_DV_OUT,
   input wire logic GIGABIT_TX_REF_IN,
   input wire logic DUPLEX_IN,
   output logic FULL_DUPLEX_OUT,
   output logic TRANSCEIVER_REF_OUT,
   output logic EXT_TRANSCEIVER_RST_N_OUT
);

   logic [SY_WIDTH-1:0] pin_vec;
   logic [SY_WIDTH-1:0] sy1_q, sy2_q, sy3_q;
   rgmp_word_s buf_in, buf_out;
   logic buf_valid, buf_pop;

   // three-stage pin synchronisers; stage one feeds only stage two
   assign pin_vec = {DUPLEX_IN, GIGABIT_TX_REF_IN, RX_CTL_IN, RXD_IN, RXC_IN};
   generate
      for (genvar i = 0; i < SY_WIDTH; i++)
      begin : g_sync
         always_ff @(posedge SYS_CLK_IN)
         begin
            if (!RESET_N_IN)
            begin
               sy1_q[i] <= 1'h0;
               sy2_q[i] <= 1'h0;
               sy3_q[i] <= 1'h0;
            end
            else
            begin
               sy1_q[i] <= pin_vec[i];
               sy2_q[i] <= sy1_q[i];
               sy3_q[i] <= sy2_q[i];
            end
         end
      end
   endgenerate

   // transmit words wait here so a slow link clock stalls the source, not drops data
   assign buf_in = '{data: TX_DATA_IN, err: TX_ERR_IN};
   rgmp_buf u_buf
   (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(RESET_N_IN),
      .in_valid_in(TX_VALID_IN),
      .in_ready_out(TX_READY_OUT),
      .in_data_in(buf_in),
      .out_valid_out(buf_valid),
      .out_ready_in(buf_pop),
      .out_data_out(buf_out)
   );

   // ---- slow level state: duplex, reference clock, transceiver reset
   logic dup_q, dup_d, gref_q, gref_d, ref_q, ref_d, xrst_n_q, xrst_n_d;
   logic [7:0] ref_cnt_q, ref_cnt_d;
   logic [15:0] hold_q, hold_d;
   logic gref_rise, gref_fall;

   assign gref_rise = sy2_q[SY_GIG_REF] & sy3_q[SY_GIG_REF] & ~gref_q;
   assign gref_fall = ~sy2_q[SY_GIG_REF] & ~sy3_q[SY_GIG_REF] & gref_q;

   always_comb
   begin
      dup_d = dup_q;
      if (sy2_q[SY_DUPLEX] == sy3_q[SY_DUPLEX])
      begin
         dup_d = sy3_q[SY_DUPLEX]; // high is full duplex
      end
      gref_d = gref_q;
      if (gref_rise || gref_fall)
      begin
         gref_d = ~gref_q;
      end
      // free-running divider, never gated by speed or reset request
      ref_cnt_d = ref_cnt_q + 8'h01;
      ref_d = ref_q;
      if (ref_cnt_q == REF_HALF - 8'h01)
      begin
         ref_cnt_d = 8'h00;
         ref_d = ~ref_q;
      end
      // a request restarts the full hold time
      hold_d = hold_q;
      if (TRANSCEIVER_RST_REQ_IN)
      begin
         hold_d = 16'h0000;
      end
      else if (hold_q != RST_HOLD_CYCLES)
      begin
         hold_d = hold_q + 16'h0001;
      end
      xrst_n_d = (hold_d == RST_HOLD_CYCLES);
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RESET_N_IN)
      begin
         dup_q <= 1'h0;
         gref_q <= 1'h0;
         ref_q <= 1'h0;
         ref_cnt_q <= 8'h00;
         hold_q <= 16'h0000;
         xrst_n_q <= 1'h0;
      end
      else
      begin
         dup_q <= dup_d;
         gref_q <= gref_d;
         ref_q <= ref_d;
         ref_cnt_q <= ref_cnt_d;
         hold_q <= hold_d;
         xrst_n_q <= xrst_n_d;
      end
   end

   assign FULL_DUPLEX_OUT = dup_q;
   assign TRANSCEIVER_REF_OUT = ref_q;
   assign EXT_TRANSCEIVER_RST_N_OUT = xrst_n_q;

   // ---- transmit side
   rgmp_speed_e spd_q, spd_d;
   rgmp_phase_e tph_q, tph_d;
   rgmp_word_s cur_q, cur_d;
   logic [7:0] div_q, div_d, half;
   logic txc_q, txc_d, busy_q, busy_d, ctl_q, ctl_d, gig, use_ref, ev_rise, ev_fall, load;
   logic [3:0] txd_q, txd_d;

   assign gig = (spd_q == RGMP_SPD_1000);
   assign use_ref = gig & USE_GIG_REF_IN;
   assign half = gig ? TXC_GIG_HALF : ((spd_q == RGMP_SPD_100) ? TXC_FAST_HALF : TXC_TEN_HALF);
   // edge events from the divider, or from the transceiver reference when selected
   assign ev_rise = use_ref ? gref_rise : ((div_q == half - 8'h01) & ~txc_q);
   assign ev_fall = use_ref ? gref_fall : ((div_q == half - 8'h01) & txc_q);
   // a new byte is fetched only where a byte boundary falls
   assign load = ev_fall & (gig | (tph_q == RGMP_PH_FIRST));
   assign buf_pop = load;

   always_comb
   begin
      spd_d = spd_q;
      tph_d = tph_q;
      cur_d = cur_q;
      busy_d = busy_q;
      ctl_d = ctl_q;
      txd_d = txd_q;
      div_d = div_q + 8'h01;
      txc_d = txc_q;
      if (ev_rise || ev_fall || (div_q >= half - 8'h01))
      begin
         div_d = 8'h00;
      end
      if (ev_rise)
      begin
         txc_d = 1'h1;
         // second half of the clock: high nibble at gigabit, error flag always
         ctl_d = busy_q & (1'h1 ^ cur_q.err);
         if (gig && busy_q)
         begin
            txd_d = cur_q.data[7:4];
         end
      end
      else if (ev_fall)
      begin
         txc_d = 1'h0;
         if (load)
         begin
            // speed may only change between frames, so no byte is split
            if (!busy_q && !buf_valid)
            begin
               spd_d = (SPEED_IN == 2'h3) ? RGMP_SPD_10 : rgmp_speed_e'(SPEED_IN);
            end
            busy_d = buf_valid;
            ctl_d = buf_valid;
            txd_d = buf_valid ? buf_out.data[3:0] : 4'h0;
            cur_d = buf_valid ? buf_out : cur_q;
            tph_d = (buf_valid && !gig) ? RGMP_PH_SECOND : RGMP_PH_FIRST;
         end
         else
         begin
            txd_d = cur_q.data[7:4]; // one nibble per clock below gigabit
            ctl_d = 1'h1;
            tph_d = RGMP_PH_FIRST;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RESET_N_IN)
      begin
         spd_q <= RGMP_SPD_10;
         tph_q <= RGMP_PH_FIRST;
         cur_q <= '0;
         busy_q <= 1'h0;
         ctl_q <= 1'h0;
         txd_q <= 4'h0;
         div_q <= 8'h00;
         txc_q <= 1'h0;
      end
      else
      begin
         spd_q <= spd_d;
         tph_q <= tph_d;
         cur_q <= cur_d;
         busy_q <= busy_d;
         ctl_q <= ctl_d;
         txd_q <= txd_d;
         div_q <= div_d;
         txc_q <= txc_d;
      end
   end

   assign TXD_OUT = txd_q;
   assign TX_CTL_OUT = ctl_q;
   assign TXC_OUT = txc_q;

   // receive side; the transceiver's clock is sampled, never used as a clock
   rgmp_phase_e rph_q, rph_d;
   logic rlvl_q, rlvl_d, rctl_q, rctl_d, rerr_q, rerr_d, rx_rise, rx_fall, er;
   logic [3:0] rnib_q, rnib_d, rlow_q, rlow_d;
   logic rv_q, rv_d, re_q, re_d, rdv_q, rdv_d;
   logic [7:0] rd_q, rd_d;

   // an edge counts once the second and third stages agree
   assign rx_rise = sy2_q[SY_RXC] & sy3_q[SY_RXC] & ~rlvl_q;
   assign rx_fall = ~sy2_q[SY_RXC] & ~sy3_q[SY_RXC] & rlvl_q;
   assign er = rctl_q ^ sy3_q[SY_RX_CTL];

   always_comb
   begin
      rlvl_d = rlvl_q;
      rctl_d = rctl_q;
      rnib_d = rnib_q;
      rlow_d = rlow_q;
      rerr_d = rerr_q;
      rph_d = rph_q;
      rd_d = rd_q;
      re_d = re_q;
      rdv_d = rdv_q;
      rv_d = 1'h0;
      if (rx_rise)
      begin
         rlvl_d = 1'h1;
         rnib_d = sy3_q[SY_RXD +: 4];
         rctl_d = sy3_q[SY_RX_CTL]; // valid on the rising edge
         rdv_d = sy3_q[SY_RX_CTL];
      end
      else if (rx_fall)
      begin
         rlvl_d = 1'h0;
         if (!rctl_q)
         begin
            rph_d = RGMP_PH_FIRST; // realign nibble pairing at every gap
         end
         else if (gig)
         begin
            rv_d = 1'h1;
            rd_d = {sy3_q[SY_RXD +: 4], rnib_q};
            re_d = er;
         end
         else if (rph_q == RGMP_PH_FIRST)
         begin
            rlow_d = rnib_q;
            rerr_d = er;
            rph_d = RGMP_PH_SECOND;
         end
         else
         begin
            rv_d = 1'h1;
            rd_d = {rnib_q, rlow_q}; // low nibble came first
            re_d = rerr_q | er;
            rph_d = RGMP_PH_FIRST;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RESET_N_IN)
      begin
         rlvl_q <= 1'h0;
         rctl_q <= 1'h0;
         rnib_q <= 4'h0;
         rlow_q <= 4'h0;
         rerr_q <= 1'h0;
         rph_q <= RGMP_PH_FIRST;
         rd_q <= 8'h00;
         re_q <= 1'h0;
         rdv_q <= 1'h0;
         rv_q <= 1'h0;
      end
      else
      begin
         rlvl_q <= rlvl_d;
         rctl_q <= rctl_d;
         rnib_q <= rnib_d;
         rlow_q <= rlow_d;
         rerr_q <= rerr_d;
         rph_q <= rph_d;
         rd_q <= rd_d;
         re_q <= re_d;
         rdv_q <= rdv_d;
         rv_q <= rv_d;
      end
   end

   assign RX_VALID_OUT = rv_q;
   assign RX_DATA_OUT = rd_q;
   assign RX_ERR_OUT = re_q;
   assign RX_DV_OUT = rdv_q;

endmodule : rgmp_port
`default_nettype wire

// File: tb/rgmp_port_asserts.sv
// concurrent checks on the rgmii pin port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rgmp_port_asserts
   import rgmp_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [1:0] SPEED_IN,
   input wire logic USE_GIG_REF_IN,
   input wire logic TRANSCEIVER_RST_REQ_IN,
   input wire logic TX_VALID_IN,
   input wire logic TX_CTL_OUT,
   input wire logic TXC_OUT,
   input wire logic RX_VALID_OUT,
   input wire logic RX_DV_OUT,
   input wire logic DUPLEX_IN,
   input wire logic FULL_DUPLEX_OUT,
   input wire logic TRANSCEIVER_REF_OUT,
   input wire logic EXT_TRANSCEIVER_RST_N_OUT
);
   logic [10:0] hold_q, hold_d;
   logic [7:0] age_q, age_d, idle_q, idle_d;
   logic [2:0] cfg_q, cfg_d;

   // saturating ages: since reset request, since speed or reference select change, since last transmit request
   always_comb
   begin
      hold_d = TRANSCEIVER_RST_REQ_IN ? 11'h000 : hold_q + 11'(hold_q != 11'h7FF);
      cfg_d = {SPEED_IN, USE_GIG_REF_IN};
      age_d = (cfg_d != cfg_q) ? 8'h00 : age_q + 8'(age_q != 8'hFF);
      idle_d = TX_VALID_IN ? 8'h00 : idle_q + 8'(idle_q != 8'hFF);
   end

   // registers only; the speed age lets a changed divider settle before timing checks
   always_ff @(posedge SYS_CLK_IN)
   begin
      hold_q <= RESET_N_IN ? hold_d : 11'h000;
      age_q <= RESET_N_IN ? age_d : 8'h00;
      idle_q <= RESET_N_IN ? idle_d : 8'h00;
      cfg_q <= cfg_d;
   end

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   a_rst_on_req: assert property (TRANSCEIVER_RST_REQ_IN |=> !EXT_TRANSCEIVER_RST_N_OUT)
      else $error("transceiver reset missing on request");
   a_rst_not_early: assert property (EXT_TRANSCEIVER_RST_N_OUT |-> hold_q >= 11'h3E3)
      else $error("transceiver reset released early");
   a_rst_not_late: assert property (hold_q >= 11'h3EE |-> EXT_TRANSCEIVER_RST_N_OUT)
      else $error("transceiver reset held too long");
   a_ref_period: assert property ($rose(TRANSCEIVER_REF_OUT) |=> TRANSCEIVER_REF_OUT ##1
      !TRANSCEIVER_REF_OUT ##1 !TRANSCEIVER_REF_OUT ##1 TRANSCEIVER_REF_OUT)
      else $error("reference clock period wrong");
   a_duplex_follow: assert property ($stable(DUPLEX_IN)[*8] |-> FULL_DUPLEX_OUT == DUPLEX_IN)
      else $error("duplex output does not follow pin");
   a_txc_gig: assert property (age_q == 8'hFF && SPEED_IN == 2'h2 && !USE_GIG_REF_IN
      && $rose(TXC_OUT) |=> !TXC_OUT) else $error("gigabit transmit clock half period wrong");
   a_txc_fast: assert property (age_q == 8'hFF && SPEED_IN == 2'h1 && $rose(TXC_OUT)
      |=> TXC_OUT ##1 !TXC_OUT) else $error("fast transmit clock half period wrong");
   a_rx_pulse: assert property (RX_VALID_OUT |=> !RX_VALID_OUT)
      else $error("receive valid longer than one cycle");
   a_rx_with_dv: assert property (RX_VALID_OUT |-> RX_DV_OUT)
      else $error("receive byte without data valid");
   a_tx_idle_ctl: assert property (idle_q == 8'hFF |-> !TX_CTL_OUT)
      else $error("transmit control high with nothing to send");
endmodule : rgmp_port_asserts

bind rgmp_port rgmp_port_asserts i_rgmp_port_asserts (.SYS_CLK_IN(SYS_CLK_IN),
   .RESET_N_IN(RESET_N_IN), .SPEED_IN(SPEED_IN), .USE_GIG_REF_IN(USE_GIG_REF_IN),
   .TRANSCEIVER_RST_REQ_IN(TRANSCEIVER_RST_REQ_IN), .TX_VALID_IN(TX_VALID_IN),
   .TX_CTL_OUT(TX_CTL_OUT), .TXC_OUT(TXC_OUT), .RX_VALID_OUT(RX_VALID_OUT),
   .RX_DV_OUT(RX_DV_OUT), .DUPLEX_IN(DUPLEX_IN), .FULL_DUPLEX_OUT(FULL_DUPLEX_OUT),
   .TRANSCEIVER_REF_OUT(TRANSCEIVER_REF_OUT),
   .EXT_TRANSCEIVER_RST_N_OUT(EXT_TRANSCEIVER_RST_N_OUT));
`default_nettype wire

// File: tb/rgmp_phy_model.sv
// behavioural external transceiver: sends receive bytes, collects transmit bytes
`timescale 1ns/1ps
`default_nettype none
module rgmp_phy_model
   import rgmp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic gig_in,
   input wire logic txc_in,
   input wire logic [3:0] txd_in,
   input wire logic tx_ctl_in,
   output logic rxc_out,
   output logic [3:0] rxd_out,
   output logic rx_ctl_out
);
   logic [3:0] d_q, lo_q, hi_q;
   logic c_q, k_q, en_q, odd_q, er_q, pend_q;
   rgmp_word_s got[$];

   initial
   begin
      rxc_out = 1'b0;
      rxd_out = 4'h0;
      rx_ctl_out = 1'b0;
      k_q = 1'b0;
      odd_q = 1'b0;
      pend_q = 1'b0;
   end

   // lines are latched with the values held just before each clock edge, as setup demands
   always @(negedge sys_clk_in)
   begin
      if (txc_in && !k_q)
      begin
         en_q = c_q;
         if (!c_q) odd_q = 1'b0;
         else if (gig_in || !odd_q)
         begin
            lo_q = d_q;
            er_q = 1'b0;
            odd_q = 1'b1;
         end
         else
         begin
            hi_q = d_q;
            pend_q = 1'b1;
         end
      end
      if (!txc_in && k_q && en_q)
      begin
         er_q = er_q | (c_q ^ en_q);
         if (gig_in || pend_q)
         begin
            got.push_back({gig_in ? d_q : hi_q, lo_q, er_q});
            pend_q = 1'b0;
            odd_q = 1'b0;
         end
      end
      k_q = txc_in;
      d_q = txd_in;
      c_q = tx_ctl_in;
   end

   // one byte on a 160 ns receive clock: one clock at gigabit, two below it
   task send(input logic [7:0] b, input logic e, input logic g);
      rxd_out = b[3:0];
      rx_ctl_out = 1'b1;
      #40 rxc_out = 1'b1;
      #40 rxd_out = g ? b[7:4] : b[3:0];
      rx_ctl_out = ~e;
      #40 rxc_out = 1'b0;
      #40;
      // below gigabit the high nibble takes a whole second clock, error repeated on its fall
      if (!g)
      begin
         rxd_out = b[7:4];
         rx_ctl_out = 1'b1;
         #40 rxc_out = 1'b1;
         #40 rx_ctl_out = ~e;
         #40 rxc_out = 1'b0;
         #40;
      end
   endtask : send

   // one idle clock closes the frame; released data shows the inverse so stale values fail
   task idle;
      rx_ctl_out = 1'b0;
      rxd_out = ~rxd_out;
      #40 rxc_out = 1'b1;
      #80 rxc_out = 1'b0;
   endtask : idle
endmodule : rgmp_phy_model
`default_nettype wire

// File: tb/rgmp_port_test.sv
// self-checking bench for the rgmii pin port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module rgmp_port_test;
   import rgmp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, use_ref = 1'b0, rq = 1'b0, tv = 1'b0, te = 1'b0;
   logic gref = 1'b0, dup = 1'b1;
   logic [1:0] spd = 2'h2;
   logic [7:0] td = 8'h00, rdata;
   logic [3:0] txd, rxd;
   logic tctl, txc, rxc, rctl, rv, rerr, rdv, fd, ref_o, ext_n, trdy;
   int n_mismatch = 0, checked = 0, nful = 0;
   rgmp_word_s rxq[$];

   always #5 clk = ~clk;
   always #40 gref = ~gref; // slowed stand-in for the transceiver's gigabit reference

   rgmp_port i_rgmp_port (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .SPEED_IN(spd),
      .USE_GIG_REF_IN(use_ref), .TRANSCEIVER_RST_REQ_IN(rq), .TX_VALID_IN(tv),
      .TX_READY_OUT(trdy), .TX_DATA_IN(td), .TX_ERR_IN(te), .TXD_OUT(txd), .TX_CTL_OUT(tctl),
      .TXC_OUT(txc), .RXC_IN(rxc), .RXD_IN(rxd), .RX_CTL_IN(rctl), .RX_VALID_OUT(rv),
      .RX_DATA_OUT(rdata), .RX_ERR_OUT(rerr), .RX_DV_OUT(rdv), .GIGABIT_TX_REF_IN(gref),
      .DUPLEX_IN(dup), .FULL_DUPLEX_OUT(fd), .TRANSCEIVER_REF_OUT(ref_o),
      .EXT_TRANSCEIVER_RST_N_OUT(ext_n));

   rgmp_phy_model i_rgmp_phy_model (.sys_clk_in(clk), .gig_in(spd == 2'h2), .txc_in(txc),
      .txd_in(txd), .tx_ctl_in(tctl), .rxc_out(rxc), .rxd_out(rxd), .rx_ctl_out(rctl));

   // valid is a one-cycle pulse; the falling edge sees it settled, once
   always @(negedge clk) if (rv === 1'b1) rxq.push_back({rdata, rerr});

   task print_verdict;
      if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // counts transmit clock rises over a window of n cycles
   task txc_rises(input int n, output int r);
      logic p;
      r = 0;
      p = txc;
      repeat (n) begin @(negedge clk); if (txc && !p) r++; p = txc; end
   endtask : txc_rises

   task t_reset;
      int k;
      int r;
      logic p;
      k = 0;
      `CHK("ext_rst_n", 1'b0, ext_n)
      while (ext_n !== 1'b1 && k < 1100) begin @(negedge clk); k++; end
      `CHK("rst_hold", 1'b1, k >= 998 && k <= 1002)
      rq = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("ext_rst_req", 1'b0, ext_n)
      rq = 1'b0;
      dup = 1'b0; // duplex falls while the transceiver restarts
      repeat (1020) @(negedge clk);
      `CHK("ext_rst_rel", 1'b1, ext_n)
      `CHK("half_duplex", 1'b0, fd)
      r = 0;
      p = ref_o;
      repeat (40)
      begin
         @(negedge clk);
         if (ref_o && !p) r++;
         p = ref_o;
      end
      `CHK("ref_rises", 40 * REF_CLK_KHZ / SYS_CLK_KHZ, r)
   endtask : t_reset

   // back-to-back bytes into the two-entry buffer, stalled while it refuses
   task push(input logic [7:0] b, input logic e);
      int k;
      @(negedge clk);
      tv = 1'b1;
      td = b;
      te = e;
      k = 0;
      // ready is judged settled at the falling edge, then the rising edge takes the byte
      while (trdy !== 1'b1 && k < 500)
      begin
         nful++;
         @(negedge clk);
         k++;
      end
      @(posedge clk);
   endtask : push

   task t_tx(input logic [1:0] s);
      logic [8:0] exp[4];
      int h, r;
      exp = '{9'h14A, 9'h079, 9'h01E, 9'h1E0};
      h = (s == 2'h2) ? int'(TXC_GIG_HALF) : (s == 2'h1) ? int'(TXC_FAST_HALF) : int'(TXC_TEN_HALF);
      @(negedge clk);
      spd = s;
      repeat (100) @(negedge clk);
      txc_rises(16 * h, r);
      `CHK("txc_rises", 8, r)
      i_rgmp_phy_model.got.delete();
      nful = 0;
      for (int i = 0; i < 4; i++) push(exp[i][8:1], exp[i][0]);
      @(negedge clk);
      tv = 1'b0;
      repeat (20 * h + 40) @(negedge clk);
      `CHK("tx_refused", 1'b1, nful > 0)
      `CHK("tx_count", 4, i_rgmp_phy_model.got.size())
      for (int i = 0; i < 4 && i < i_rgmp_phy_model.got.size(); i++)
         `CHK("tx_word", exp[i], i_rgmp_phy_model.got[i])
      if (s == 2'h2)
      begin
         use_ref = 1'b1;
         repeat (50) @(negedge clk);
         txc_rises(800, r);
         `CHK("txc_follow_ref", 100, r)
         use_ref = 1'b0;
      end
   endtask : t_tx

   task t_rx(input logic [1:0] s);
      @(negedge clk);
      spd = s;
      dup = 1'b1;
      rxq.delete();
      // receive pairing follows the speed only once the transmit side has taken it between frames
      repeat (100) @(negedge clk);
      i_rgmp_phy_model.send(8'h5A, 1'b0, s == 2'h2);
      i_rgmp_phy_model.send(8'hC3, 1'b1, s == 2'h2);
      i_rgmp_phy_model.send(8'hFF, 1'b0, s == 2'h2);
      i_rgmp_phy_model.idle();
      repeat (20) @(negedge clk);
      `CHK("rx_count", 3, rxq.size())
      if (rxq.size() == 3)
      begin
         `CHK("rx_b0", 9'h0B4, rxq[0])
         `CHK("rx_b1", 9'h187, rxq[1])
         `CHK("rx_b2", 9'h1FE, rxq[2])
      end
      `CHK("rx_dv_idle", 1'b0, rdv)
      `CHK("full_duplex", 1'b1, fd)
   endtask : t_rx

   // main sequence: reset, transceiver reset, transmit at each speed, receive
   initial
   begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_reset;
      t_tx(2'h2);
      t_tx(2'h1);
      t_tx(2'h0);
      t_rx(2'h2);
      t_rx(2'h1);
      print_verdict;
   end

   // watchdog well past the expected run of some five thousand cycles
   initial
   begin
      #500000;
      n_mismatch++;
      print_verdict;
   end
endmodule : rgmp_port_test
`default_nettype wire
